//--- pkg/fci_defines.vh
// Constants for the fragment colour interpolator
`ifndef FCI_DEFINES_VH
`define FCI_DEFINES_VH
`define FCI_W_FIX 17
`define FCI_FRAC 11
`define FCI_ACC_INT 9
`define FCI_A_RED_START 8'h00
`define FCI_A_RED_DX 8'h04
`define FCI_A_RED_DOM 8'h08
`define FCI_A_GRN_START 8'h0c
`define FCI_A_GRN_DX 8'h10
`define FCI_A_GRN_DOM 8'h14
`define FCI_A_BLU_START 8'h18
`define FCI_A_BLU_DX 8'h1c
`define FCI_A_BLU_DOM 8'h20
`define FCI_A_ALP_START 8'h24
`define FCI_A_FLAT 8'h28
`define FCI_A_CTRL 8'h2c
`define FCI_A_STATUS 8'h30
`define FCI_CTRL_ON 0
`define FCI_CTRL_SHADE 1
`define FCI_CTRL_PAL 2
`define FCI_SHADE_FLAT 1'b0
`define FCI_SHADE_GOURAUD 1'b1
`define FCI_RESP_OKAY 2'b00
`define FCI_RESP_SLVERR 2'b10
`define FCI_RST_FIX 17'h00000
`define FCI_RST_WORD 32'h00000000
`define FCI_RST_CTRL 3'h0
`endif

//--- rtl/fci_channel.v
// One colour channel: dominant-edge and span accumulators, loaded from the start value
module fci_channel #(
  parameter W = 17,
  parameter F = 11
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] start_val,
  input wire [W-1:0] step_x,
  input wire [W-1:0] step_dom,
  input wire load,
  input wire new_line,
  input wire step_span,
  input wire [W-1:0] sub_x,
  input wire [W-1:0] sub_y,
  input wire sub_on,
  output wire [W-1:0] span_acc
);
  reg [W-1:0] edge_ff;
  reg [W-1:0] span_ff;
  reg [W-1:0] nxt_edge;
  reg [W-1:0] nxt_span;

  // Fixed-point product of step and subpixel fraction
  function [W-1:0] fmul;
    input [W-1:0] a;
    input [W-1:0] b;
    reg signed [2*W-1:0] p;
    begin
      p = $signed(a) * $signed(b);
      fmul = p[F+W-1:F];
    end
  endfunction

  always @* begin
    nxt_edge = edge_ff;
    nxt_span = span_ff;
    if (load) begin
      nxt_edge = sub_on ? start_val + fmul(step_dom, sub_y) : start_val;
      nxt_span = sub_on ? nxt_edge + fmul(step_x, sub_x) : nxt_edge;
    end else if (new_line) begin
      nxt_edge = edge_ff + step_dom;
      nxt_span = sub_on ? nxt_edge + fmul(step_x, sub_x) : nxt_edge;
    end else if (step_span) begin
      nxt_span = span_ff + step_x;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      edge_ff <= {W{1'b0}};
      span_ff <= {W{1'b0}};
    end else begin
      edge_ff <= nxt_edge;
      span_ff <= nxt_span;
    end
  end

  // Stepped value, so each fragment carries its own step
  assign span_acc = nxt_span;
endmodule

//--- rtl/fci_clamp.v
// Clamp of a fixed-point colour accumulator to an 8-bit component
module fci_clamp #(
  parameter W = 17,
  parameter F = 11
) (
  input wire [W-1:0] acc,
  output reg [7:0] comp
);
  always @* begin
    if (acc[W-1]) begin
      comp = 8'h00;
    end else if (|acc[W-2:F+8]) begin
      comp = 8'hff;
    end else begin
      comp = acc[F+7:F];
    end
  end
endmodule

//--- rtl/fci_top.v
// Fragment colour interpolator with AXI4-Lite register file
`include "fci_defines.vh"
module fci_top #(
  parameter W = 17,
  parameter F = 11
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire render_start,
  input wire is_line,
  input wire sub_on,
  input wire [W-1:0] sub_x,
  input wire [W-1:0] sub_y,
  input wire frag_valid,
  input wire frag_new_line,
  output wire frag_ready,
  output wire out_valid,
  input wire out_ready,
  output wire out_has_color,
  output wire [31:0] out_color
);
  ////////////////////////////////////////////////////////////////////////
  // Register file
  reg [W-1:0] red_start_value_ff;
  reg [W-1:0] red_step_x_ff;
  reg [W-1:0] red_step_dominant_ff;
  reg [W-1:0] green_start_value_ff;
  reg [W-1:0] green_step_x_ff;
  reg [W-1:0] green_step_dominant_ff;
  reg [W-1:0] blue_start_value_ff;
  reg [W-1:0] blue_step_x_ff;
  reg [W-1:0] blue_step_dominant_ff;
  reg [W-1:0] alpha_start_value_ff;
  reg [31:0] flat_color_value_ff;
  reg [2:0] interp_unit_control_ff;
  reg [7:0] waddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg aw_ok_ff;
  reg w_ok_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;
  reg [31:0] rd_word;
  reg rd_hit;
  reg wr_hit;
  wire wr_go;
  wire rd_go;
  wire interp_unit_on;
  wire shade_gouraud;
  wire palette_index_mode;
  wire [31:0] ctrl_merged;

  // Merge write strobes into an existing word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // Strobe merge into a fixed-point field, upper bus bits dropped
  function [W-1:0] merge_fix;
    input [W-1:0] old;
    input [31:0] data;
    input [3:0] strb;
    reg [31:0] word;
    begin
      word = merge({{(32-W){1'b0}}, old}, data, strb);
      merge_fix = word[W-1:0];
    end
  endfunction

  // Address decode shared by read and write
  function hit;
    input [7:0] a;
    begin
      hit = (a[1:0] == 2'b00) && (a <= `FCI_A_STATUS);
    end
  endfunction

  assign interp_unit_on = interp_unit_control_ff[`FCI_CTRL_ON];
  assign shade_gouraud = interp_unit_control_ff[`FCI_CTRL_SHADE];
  assign palette_index_mode = interp_unit_control_ff[`FCI_CTRL_PAL];
  assign ctrl_merged = merge({29'h0000000, interp_unit_control_ff}, wdata_ff, wstrb_ff);

  assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
  assign s_axi_wready = !w_ok_ff && !bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign wr_go = aw_ok_ff && w_ok_ff;
  assign rd_go = s_axi_arvalid && !rvalid_ff;

  always @* begin
    wr_hit = hit(waddr_ff) && (waddr_ff != `FCI_A_STATUS);
    rd_hit = hit(s_axi_araddr);
    case (s_axi_araddr)
      `FCI_A_RED_START: rd_word = {{(32-W){1'b0}}, red_start_value_ff};
      `FCI_A_RED_DX: rd_word = {{(32-W){1'b0}}, red_step_x_ff};
      `FCI_A_RED_DOM: rd_word = {{(32-W){1'b0}}, red_step_dominant_ff};
      `FCI_A_GRN_START: rd_word = {{(32-W){1'b0}}, green_start_value_ff};
      `FCI_A_GRN_DX: rd_word = {{(32-W){1'b0}}, green_step_x_ff};
      `FCI_A_GRN_DOM: rd_word = {{(32-W){1'b0}}, green_step_dominant_ff};
      `FCI_A_BLU_START: rd_word = {{(32-W){1'b0}}, blue_start_value_ff};
      `FCI_A_BLU_DX: rd_word = {{(32-W){1'b0}}, blue_step_x_ff};
      `FCI_A_BLU_DOM: rd_word = {{(32-W){1'b0}}, blue_step_dominant_ff};
      `FCI_A_ALP_START: rd_word = {{(32-W){1'b0}}, alpha_start_value_ff};
      `FCI_A_FLAT: rd_word = flat_color_value_ff;
      `FCI_A_CTRL: rd_word = {29'h0000000, interp_unit_control_ff};
      `FCI_A_STATUS: rd_word = out_color;
      default: rd_word = `FCI_RST_WORD;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      waddr_ff <= 8'h00;
      wdata_ff <= `FCI_RST_WORD;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `FCI_RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= `FCI_RST_WORD;
      rresp_ff <= `FCI_RESP_OKAY;
      red_start_value_ff <= `FCI_RST_FIX;
      red_step_x_ff <= `FCI_RST_FIX;
      red_step_dominant_ff <= `FCI_RST_FIX;
      green_start_value_ff <= `FCI_RST_FIX;
      green_step_x_ff <= `FCI_RST_FIX;
      green_step_dominant_ff <= `FCI_RST_FIX;
      blue_start_value_ff <= `FCI_RST_FIX;
      blue_step_x_ff <= `FCI_RST_FIX;
      blue_step_dominant_ff <= `FCI_RST_FIX;
      alpha_start_value_ff <= `FCI_RST_FIX;
      flat_color_value_ff <= `FCI_RST_WORD;
      interp_unit_control_ff <= `FCI_RST_CTRL;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff <= 1'b1;
        waddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? `FCI_RESP_OKAY : `FCI_RESP_SLVERR;
        if (wr_hit) begin
          case (waddr_ff)
            `FCI_A_RED_START: red_start_value_ff <=
              merge_fix(red_start_value_ff, wdata_ff, wstrb_ff);
            `FCI_A_RED_DX: red_step_x_ff <=
              merge_fix(red_step_x_ff, wdata_ff, wstrb_ff);
            `FCI_A_RED_DOM: red_step_dominant_ff <=
              merge_fix(red_step_dominant_ff, wdata_ff, wstrb_ff);
            `FCI_A_GRN_START: green_start_value_ff <=
              merge_fix(green_start_value_ff, wdata_ff, wstrb_ff);
            `FCI_A_GRN_DX: green_step_x_ff <=
              merge_fix(green_step_x_ff, wdata_ff, wstrb_ff);
            `FCI_A_GRN_DOM: green_step_dominant_ff <=
              merge_fix(green_step_dominant_ff, wdata_ff, wstrb_ff);
            `FCI_A_BLU_START: blue_start_value_ff <=
              merge_fix(blue_start_value_ff, wdata_ff, wstrb_ff);
            `FCI_A_BLU_DX: blue_step_x_ff <=
              merge_fix(blue_step_x_ff, wdata_ff, wstrb_ff);
            `FCI_A_BLU_DOM: blue_step_dominant_ff <=
              merge_fix(blue_step_dominant_ff, wdata_ff, wstrb_ff);
            `FCI_A_ALP_START: alpha_start_value_ff <=
              merge_fix(alpha_start_value_ff, wdata_ff, wstrb_ff);
            `FCI_A_FLAT: flat_color_value_ff <=
              merge(flat_color_value_ff, wdata_ff, wstrb_ff);
            `FCI_A_CTRL: interp_unit_control_ff <=
              ctrl_merged[2:0];
            default: bresp_ff <= `FCI_RESP_SLVERR;
          endcase
        end
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      if (rd_go) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_word;
        rresp_ff <= rd_hit ? `FCI_RESP_OKAY : `FCI_RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interpolation datapath
  // Accumulator: sign, 8 colour bits plus one overflow bit, fraction
  localparam AW = F + `FCI_ACC_INT + 1;
  wire [AW-1:0] red_acc;
  wire [AW-1:0] green_acc;
  wire [AW-1:0] blue_acc;
  wire [AW-1:0] ext_red_start;
  wire [AW-1:0] ext_red_dx;
  wire [AW-1:0] ext_red_dom;
  wire [AW-1:0] ext_grn_start;
  wire [AW-1:0] ext_grn_dx;
  wire [AW-1:0] ext_grn_dom;
  wire [AW-1:0] ext_blu_start;
  wire [AW-1:0] ext_blu_dx;
  wire [AW-1:0] ext_blu_dom;
  wire [AW-1:0] ext_alp_start;
  wire [AW-1:0] ext_sub_x;
  wire [AW-1:0] ext_sub_y;
  wire [7:0] red_c;
  wire [7:0] green_c;
  wire [7:0] blue_c;
  wire [7:0] alpha_c;
  wire take;
  wire step_span;
  wire new_line;
  reg first_ff;
  reg line_ff;
  reg out_valid_ff;
  reg out_has_color_ff;
  reg [31:0] out_color_ff;
  reg [31:0] nxt_color;

  assign frag_ready = !out_valid_ff || out_ready;
  assign take = frag_valid && frag_ready;
  // Lines never take a per-X step, each fragment walks the edge
  assign new_line = take && !first_ff && (frag_new_line || line_ff);
  assign step_span = take && !first_ff && !frag_new_line && !line_ff;

  // Sign extension of a register field to accumulator width
  function [AW-1:0] sext;
    input [W-1:0] v;
    begin
      sext = {{(AW-W){v[W-1]}}, v};
    end
  endfunction

  // Headroom above the register format lets overflow reach the clamp
  assign ext_red_start = sext(red_start_value_ff);
  assign ext_red_dx = sext(red_step_x_ff);
  assign ext_red_dom = sext(red_step_dominant_ff);
  assign ext_grn_start = sext(green_start_value_ff);
  assign ext_grn_dx = sext(green_step_x_ff);
  assign ext_grn_dom = sext(green_step_dominant_ff);
  assign ext_blu_start = sext(blue_start_value_ff);
  assign ext_blu_dx = sext(blue_step_x_ff);
  assign ext_blu_dom = sext(blue_step_dominant_ff);
  assign ext_alp_start = sext(alpha_start_value_ff);
  assign ext_sub_x = sext(sub_x);
  assign ext_sub_y = sext(sub_y);

  fci_channel #(.W(AW), .F(F)) u_red (
    .aclk(aclk), .aresetn(aresetn),
    .start_val(ext_red_start), .step_x(ext_red_dx),
    .step_dom(ext_red_dom), .load(render_start),
    .new_line(new_line), .step_span(step_span),
    .sub_x(ext_sub_x), .sub_y(ext_sub_y), .sub_on(sub_on), .span_acc(red_acc)
  );
  fci_channel #(.W(AW), .F(F)) u_green (
    .aclk(aclk), .aresetn(aresetn),
    .start_val(ext_grn_start), .step_x(ext_grn_dx),
    .step_dom(ext_grn_dom), .load(render_start),
    .new_line(new_line), .step_span(step_span),
    .sub_x(ext_sub_x), .sub_y(ext_sub_y), .sub_on(sub_on), .span_acc(green_acc)
  );
  fci_channel #(.W(AW), .F(F)) u_blue (
    .aclk(aclk), .aresetn(aresetn),
    .start_val(ext_blu_start), .step_x(ext_blu_dx),
    .step_dom(ext_blu_dom), .load(render_start),
    .new_line(new_line), .step_span(step_span),
    .sub_x(ext_sub_x), .sub_y(ext_sub_y), .sub_on(sub_on), .span_acc(blue_acc)
  );

  fci_clamp #(.W(AW), .F(F)) u_cr (.acc(red_acc), .comp(red_c));
  fci_clamp #(.W(AW), .F(F)) u_cg (.acc(green_acc), .comp(green_c));
  fci_clamp #(.W(AW), .F(F)) u_cb (.acc(blue_acc), .comp(blue_c));
  fci_clamp #(.W(AW), .F(F)) u_ca (.acc(ext_alp_start), .comp(alpha_c));

  always @* begin
    if (shade_gouraud == `FCI_SHADE_FLAT) begin
      nxt_color = flat_color_value_ff;
    end else if (palette_index_mode) begin
      nxt_color = {24'h000000, red_c};
    end else begin
      nxt_color = {alpha_c, blue_c, green_c, red_c};
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      first_ff <= 1'b1;
      line_ff <= 1'b0;
      out_valid_ff <= 1'b0;
      out_has_color_ff <= 1'b0;
      out_color_ff <= `FCI_RST_WORD;
    end else begin
      if (render_start) begin
        first_ff <= 1'b1;
        line_ff <= is_line;
      end else if (take) begin
        first_ff <= 1'b0;
      end
      if (take) begin
        out_valid_ff <= 1'b1;
        out_has_color_ff <= interp_unit_on;
        out_color_ff <= interp_unit_on ? nxt_color : `FCI_RST_WORD;
      end else if (out_ready) begin
        out_valid_ff <= 1'b0;
      end
    end
  end

  assign out_valid = out_valid_ff;
  assign out_has_color = out_has_color_ff;
  assign out_color = out_color_ff;
endmodule

//--- verification/fci_raster_model.sv
// Fragment source standing in for the rasterizer
module fci_raster_model (
  input wire logic aclk,
  input wire logic frag_ready,
  output logic frag_valid,
  output logic frag_new_line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    frag_valid = 1'b0;
    frag_new_line = 1'b0;
  end
  // Back-to-back fragments, each held until taken
  task automatic send(input int n, input logic [15:0] nlm, output bit ok);
    int k;
    ok = 1;
    for (int i = 0; i < n; i++) begin
      frag_valid <= 1'b1;
      frag_new_line <= nlm[i];
      k = 0;
      do begin
        @(posedge aclk);
        k++;
      end while (!frag_ready && k < 50);
      if (k >= 50) ok = 0;
    end
    frag_valid <= 1'b0;
    frag_new_line <= ~nlm[n-1];
  endtask
endmodule

//--- verification/fci_top_checker.sv
// Bus and fragment stream assertions for the colour interpolator
module fci_top_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frag_valid,
  input wire logic frag_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic out_has_color,
  input wire logic [31:0] out_color
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  write_answer_a: assert property (both_taken |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  bresp_hold_a: assert property (resp_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  busy_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed");
  frag_ready_a: assert property (frag_ready == (!out_valid || out_ready))
    else $error("fragment ready wrong");
  frag_answer_a: assert property (frag_valid && frag_ready |=> out_valid)
    else $error("fragment output missing");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_color))
    else $error("stalled colour changed");
  uncolored_zero_a: assert property (out_valid && !out_has_color |-> out_color == 32'h0)
    else $error("uncoloured fragment has colour");
endmodule
bind fci_top fci_top_checker i_fci_top_checker (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .frag_valid, .frag_ready,
  .out_valid, .out_ready, .out_has_color, .out_color);

//--- verification/tb_fci_top.sv
// Self-checking bench for the fragment colour interpolator
`include "fci_defines.vh"
module tb_fci_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, render_start = 1'b0, is_line = 1'b0, out_ready = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sub_on = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, flat_v = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf, stb = 4'hf;
  logic [16:0] sub_x = 17'h0, sub_y = 17'h0;
  logic [2:0] mode = 3'h0;
  logic [1:0] cyc = 2'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire frag_valid, frag_new_line, frag_ready, out_valid, out_has_color;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, out_color;
  int error_cnt = 0, n_checks = 0;
  int st[3] = '{10, 31, 2}, dx[3] = '{1, 31, -1}, dy[3] = '{4, 0, -3}, eg[3], sp[3];
  bit first = 1;
  logic [32:0] exp_q[$];
  fci_top i_fci_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .render_start, .is_line, .sub_on, .sub_x, .sub_y,
    .frag_valid, .frag_new_line, .frag_ready, .out_valid, .out_ready, .out_has_color,
    .out_color);
  fci_raster_model i_fci_raster_model (.aclk, .frag_ready, .frag_valid, .frag_new_line);
  initial forever #10 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  function automatic logic [31:0] fx(input int v);
    return {15'h0, 17'(v * 2048)};
  endfunction
  // Register access: response ready raised at the third edge, so the slave must hold
  task automatic acc(input bit w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= stb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
    end
    forever begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        chk(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
        break;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        chk(s_axi_rdata, d);
        chk(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
        break;
      end
      if (n == 3) begin
        s_axi_bready <= w;
        s_axi_rready <= !w;
      end
      if (n > 50) begin
        error_cnt++;
        give_verdict();
      end
    end
  endtask
  task automatic setm(input logic [2:0] m);
    acc(1, `FCI_A_CTRL, {29'h0, m}, `FCI_RESP_OKAY);
    mode = m;
  endtask
  task automatic render(input bit ln);
    is_line <= ln;
    render_start <= 1'b1;
    @(posedge aclk);
    render_start <= 1'b0;
    first = 1;
  endtask
  // Expected colours of a burst, then the burst itself
  task automatic frags(input int n, input logic [15:0] m);
    logic [7:0] c[3];
    bit ok;
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < 3; k++) begin
        // Subpixel fractions are 1.0, adding one whole step
        if (first) begin
          eg[k] = st[k] + (sub_on ? dy[k] : 0);
          sp[k] = eg[k] + (sub_on ? dx[k] : 0);
        end else if (m[i] || is_line) begin
          eg[k] += dy[k];
          sp[k] = eg[k] + (sub_on ? dx[k] : 0);
        end else sp[k] += dx[k];
        c[k] = sp[k] < 0 ? 8'h00 : sp[k] > 255 ? 8'hff : 8'(sp[k]);
      end
      first = 0;
      if (!mode[0]) exp_q.push_back(33'h0);
      else if (!mode[1]) exp_q.push_back({1'b1, flat_v});
      else if (mode[2]) exp_q.push_back({1'b1, 24'h0, c[0]});
      else exp_q.push_back({1'b1, 8'h07, c[2], c[1], c[0]});
    end
    i_fci_raster_model.send(n, m, ok);
    for (int t = 0; t < 100 && exp_q.size() > 0; t++) @(posedge aclk);
    if (!ok || exp_q.size() != 0) begin
      error_cnt++;
      give_verdict();
    end
    $display("test done mode %h", mode);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    cyc <= cyc + 2'h1;
    out_ready <= (cyc != 2'h3);
    if (aresetn && out_valid && out_ready)
      chk({out_has_color, out_color}, exp_q.size() > 0 ? exp_q.pop_front() : 33'h0);
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 13; i++) acc(0, 8'(4 * i), 32'h0, `FCI_RESP_OKAY);
    acc(1, 8'h40, 32'h0, `FCI_RESP_SLVERR);
    acc(0, 8'h40, 32'h0, `FCI_RESP_SLVERR);
    acc(1, `FCI_A_STATUS, 32'h0, `FCI_RESP_SLVERR);
    acc(1, `FCI_A_RED_START, 32'hffffffff, `FCI_RESP_OKAY);
    acc(0, `FCI_A_RED_START, 32'h0001ffff, `FCI_RESP_OKAY);
    $display("test done registers");
    for (int k = 0; k < 3; k++) begin
      acc(1, 8'(12 * k), fx(st[k]), `FCI_RESP_OKAY);
      acc(1, 8'(12 * k + 4), fx(dx[k]), `FCI_RESP_OKAY);
      acc(1, 8'(12 * k + 8), fx(dy[k]), `FCI_RESP_OKAY);
      acc(0, 8'(12 * k + 8), fx(dy[k]), `FCI_RESP_OKAY);
    end
    acc(1, `FCI_A_ALP_START, fx(7), `FCI_RESP_OKAY);
    setm(3'h3);
    render(0);
    frags(10, 16'h0200);
    render(1);
    frags(3, 16'h0);
    sub_x <= 17'h00800;
    sub_y <= 17'h00800;
    sub_on <= 1'b1;
    render(0);
    frags(3, 16'h4);
    sub_on <= 1'b0;
    setm(3'h7);
    render(0);
    frags(2, 16'h2);
    acc(1, `FCI_A_FLAT, 32'hf0804000, `FCI_RESP_OKAY);
    stb = 4'h1;
    acc(1, `FCI_A_FLAT, 32'h000000a0, `FCI_RESP_OKAY);
    stb = 4'hf;
    flat_v = 32'hf08040a0;
    acc(0, `FCI_A_FLAT, flat_v, `FCI_RESP_OKAY);
    setm(3'h1);
    render(0);
    frags(2, 16'h0);
    acc(0, `FCI_A_STATUS, flat_v, `FCI_RESP_OKAY);
    setm(3'h0);
    render(0);
    frags(2, 16'h0);
    give_verdict();
  end
endmodule
